// ---- src/brf_map.vh ----
// register offsets, reset values and field positions for the register file
`ifndef BRF_MAP_VH
`define BRF_MAP_VH
`define BRF_ADDR_W 8
`define BRF_DATA_W 8
`define BRF_PORT_REGS 8'h04
`define BRF_CTRL_BASE 8'hF0
`define BRF_PORT2_MODE 8'hF6
`define BRF_PORT3_MODE 8'hF7
`define BRF_PORT01_MODE 8'hF8
`define BRF_INT_PRIO 8'hF9
`define BRF_INT_REQ 8'hFA
`define BRF_INT_MASK 8'hFB
`define BRF_FLAGS 8'hFC
`define BRF_REG_PTR 8'hFD
`define BRF_SP_HIGH 8'hFE
`define BRF_SP_LOW 8'hFF
`define BRF_RST_ZERO 8'h00
`define BRF_RST_PORT01_MODE 8'hCF
`define BRF_GRP_HI 7
`define BRF_GRP_LO 4
`define BRF_BANK_HI 3
`define BRF_BANK_LO 0
`define BRF_WORK_NIB 4'hE
`define BRF_BANK_D 4'hD
`define BRF_BANK_F 4'hF
`define BRF_BANK_NONE 4'h0
`define BRF_LOW_WIN_HI 4'h0
`endif

// ---- src/brf_register_file.v ----
// banked register file with working-group and expanded-bank mapping
//
// Behaviour
// - provide 256 byte-wide primary register locations for the core
// - primary space holds 4 port, 16 control/status, 236 general registers
// - expanded register space adds groups F and D beyond primary space
// - low sixteen addresses map to primary space, bank D or bank F of 16 registers; other banks read zero
// - register_pointer bits 7..4 choose working group for short addressing
// - register_pointer bits 3..0 choose bank mapped into low sixteen window
`timescale 1ns/1ps
`include "brf_map.vh"
module brf_register_file #(
  parameter GP_WORDS = 236,
  parameter BANK_REGS = 16
) (
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output reg [7:0] port_out_0,
  output reg [7:0] port_out_1,
  output reg [7:0] port_out_2,
  output reg [7:0] port_out_3,
  output wire [3:0] working_group,
  output wire [3:0] expanded_bank
);
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg [7:0] port2_mode;
  reg [7:0] port3_mode;
  reg [7:0] port0_port1_mode;
  reg [7:0] interrupt_priority;
  reg [7:0] interrupt_request;
  reg [7:0] interrupt_mask;
  reg [7:0] condition_flags;
  reg [7:0] register_pointer;
  reg [7:0] stack_pointer_high;
  reg [7:0] stack_pointer_low;
  // ----------------------------------------------------------------
  // storage: general registers and expanded banks
  // ----------------------------------------------------------------
  reg [7:0] gp_mem [0:GP_WORDS-1];
  reg [7:0] bank_d [0:BANK_REGS-1];
  reg [7:0] bank_f [0:BANK_REGS-1];
  reg [7:0] next_rdata;

  assign working_group = register_pointer[`BRF_GRP_HI:`BRF_GRP_LO];
  assign expanded_bank = register_pointer[`BRF_BANK_HI:`BRF_BANK_LO];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // short working-register form 0xE0..0xEF is relocated to the group
  wire short_form = (addr[7:4] == `BRF_WORK_NIB);
  wire [7:0] eff_addr = short_form ? {working_group, addr[3:0]} : addr;
  wire low_win = (eff_addr[7:4] == `BRF_LOW_WIN_HI);
  wire to_bank = low_win && (expanded_bank != `BRF_BANK_NONE);
  wire hit_d = to_bank && (expanded_bank == `BRF_BANK_D);
  wire hit_f = to_bank && (expanded_bank == `BRF_BANK_F);
  wire is_port = !to_bank && (eff_addr < `BRF_PORT_REGS);
  wire is_ctrl = (eff_addr >= `BRF_CTRL_BASE);
  wire is_gp = !to_bank && !is_port && !is_ctrl;
  wire [7:0] gp_idx = eff_addr - `BRF_PORT_REGS;
  wire [3:0] bidx = eff_addr[3:0];

  // ----------------------------------------------------------------
  // general and bank storage, one always block per entry from a generate loop
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < GP_WORDS; gi = gi + 1) begin : g_gp
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          gp_mem[gi] <= `BRF_RST_ZERO;
        end else if (clk_en && wr && is_gp && gp_idx == gi) begin
          gp_mem[gi] <= wdata;
        end
      end
    end
    for (gi = 0; gi < BANK_REGS; gi = gi + 1) begin : g_bank
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          bank_d[gi] <= `BRF_RST_ZERO;
          bank_f[gi] <= `BRF_RST_ZERO;
        end else if (clk_en && wr && bidx == gi) begin
          if (hit_d) begin
            bank_d[gi] <= wdata;
          end
          if (hit_f) begin
            bank_f[gi] <= wdata;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // port and control registers
  // ----------------------------------------------------------------
  // reset values not given are cleared so that state is defined
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_out_0 <= `BRF_RST_ZERO;
      port_out_1 <= `BRF_RST_ZERO;
      port_out_2 <= `BRF_RST_ZERO;
      port_out_3 <= `BRF_RST_ZERO;
      port2_mode <= `BRF_RST_ZERO;
      port3_mode <= `BRF_RST_ZERO;
      port0_port1_mode <= `BRF_RST_PORT01_MODE;
      interrupt_priority <= `BRF_RST_ZERO;
      interrupt_request <= `BRF_RST_ZERO;
      interrupt_mask <= `BRF_RST_ZERO;
      condition_flags <= `BRF_RST_ZERO;
      register_pointer <= `BRF_RST_ZERO;
      stack_pointer_high <= `BRF_RST_ZERO;
      stack_pointer_low <= `BRF_RST_ZERO;
    end else if (clk_en && wr) begin
      if (is_port) begin
        case (eff_addr[1:0])
          2'h0: begin
            port_out_0 <= wdata;
          end
          2'h1: begin
            port_out_1 <= wdata;
          end
          2'h2: begin
            port_out_2 <= wdata;
          end
          default: begin
            port_out_3 <= wdata;
          end
        endcase
      end
      // control block is never banked, so the full effective address
      // decides; reserved control slots simply drop the write
      case (eff_addr)
        `BRF_PORT2_MODE: begin
          port2_mode <= wdata;
        end
        `BRF_PORT3_MODE: begin
          port3_mode <= wdata;
        end
        `BRF_PORT01_MODE: begin
          port0_port1_mode <= wdata;
        end
        `BRF_INT_PRIO: begin
          interrupt_priority <= wdata;
        end
        `BRF_INT_REQ: begin
          interrupt_request <= wdata;
        end
        `BRF_INT_MASK: begin
          interrupt_mask <= wdata;
        end
        `BRF_FLAGS: begin
          condition_flags <= wdata;
        end
        `BRF_REG_PTR: begin
          // new pointer steers decode from the next cycle on
          register_pointer <= wdata;
        end
        `BRF_SP_HIGH: begin
          stack_pointer_high <= wdata;
        end
        `BRF_SP_LOW: begin
          stack_pointer_low <= wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = `BRF_RST_ZERO;
    if (hit_d) begin
      next_rdata = bank_d[bidx];
    end else if (hit_f) begin
      next_rdata = bank_f[bidx];
    end else if (to_bank) begin
      // unimplemented banks read zero
      next_rdata = `BRF_RST_ZERO;
    end else if (is_port) begin
      case (eff_addr[1:0])
        2'h0: begin
          next_rdata = port_out_0;
        end
        2'h1: begin
          next_rdata = port_out_1;
        end
        2'h2: begin
          next_rdata = port_out_2;
        end
        default: begin
          next_rdata = port_out_3;
        end
      endcase
    end else if (is_gp) begin
      next_rdata = gp_mem[gp_idx];
    end else begin
      // reserved control slots read zero
      case (eff_addr)
        `BRF_PORT2_MODE: begin
          next_rdata = port2_mode;
        end
        `BRF_PORT3_MODE: begin
          next_rdata = port3_mode;
        end
        `BRF_PORT01_MODE: begin
          next_rdata = port0_port1_mode;
        end
        `BRF_INT_PRIO: begin
          next_rdata = interrupt_priority;
        end
        `BRF_INT_REQ: begin
          next_rdata = interrupt_request;
        end
        `BRF_INT_MASK: begin
          next_rdata = interrupt_mask;
        end
        `BRF_FLAGS: begin
          next_rdata = condition_flags;
        end
        `BRF_REG_PTR: begin
          next_rdata = register_pointer;
        end
        `BRF_SP_HIGH: begin
          next_rdata = stack_pointer_high;
        end
        `BRF_SP_LOW: begin
          next_rdata = stack_pointer_low;
        end
        default: begin
          next_rdata = `BRF_RST_ZERO;
        end
      endcase
    end
  end

  // read data is held between reads so a stalled core sees no glitch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `BRF_RST_ZERO;
    end else if (clk_en && rd) begin
      rdata <= next_rdata;
    end
  end
endmodule

// ---- verification/brf_core_model.sv ----
// behavioural core issuing register bus cycles
`timescale 1ns/1ps
module brf_core_model(
  input wire clk,
  output reg [7:0] addr = 8'h00,
  output reg [7:0] wdata = 8'h00,
  output reg wr = 1'b0,
  output reg rd = 1'b0
);
  task cyc(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
  endtask
  // released bus shows fresh values, never the last ones
  task idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
endmodule

// ---- verification/brf_register_file_monitor.sv ----
// port assertions for the register file
`timescale 1ns/1ps
module brf_register_file_monitor(
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [7:0] port_out_0,
  input wire [3:0] working_group,
  input wire [3:0] expanded_bank
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire w_ok = wr & clk_en;
  wire r_ok = rd & clk_en;
  wire [3:0] bk = expanded_bank;
  a_group_take:
    assert property (w_ok && addr == 8'hFD |=>
      working_group == $past(wdata[7:4])) else $error("group not taken");
  a_bank_take:
    assert property (w_ok && addr == 8'hFD |=>
      bk == $past(wdata[3:0])) else $error("bank not taken");
  a_ptr_read:
    assert property (r_ok && addr == 8'hFD |=>
      rdata == $past({working_group, bk})) else $error("pointer read");
  a_port_write:
    assert property (w_ok && addr == 8'h00 && bk == 4'h0 |=>
      port_out_0 == $past(wdata)) else $error("port write lost");
  a_ctrl_gap:
    assert property (r_ok && addr == 8'hF0 |=> rdata == 8'h00)
      else $error("reserved read not zero");
  a_empty_bank:
    assert property (r_ok && addr < 8'h10 && bk != 4'h0 && bk != 4'hD
      && bk != 4'hF |=> rdata == 8'h00) else $error("empty bank read");
  a_rdata_hold:
    assert property (!r_ok |=> $stable(rdata)) else $error("rdata moved");
  a_frozen_state:
    assert property (!clk_en |=> $stable({working_group, bk, port_out_0}))
      else $error("state moved while frozen");
endmodule
bind brf_register_file brf_register_file_monitor brf_mon_inst(.clk(clk),
  .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .port_out_0(port_out_0), .working_group(working_group),
  .expanded_bank(expanded_bank));

// ---- verification/tb.sv ----
// self-checking bench for the banked register file
`timescale 1ns/1ps
module tb;
  reg clk = 0;
  reg rst = 1;
  reg clk_en = 1;
  wire [7:0] addr, wdata, rdata, p0, p1, p2, p3;
  wire wr, rd;
  wire [3:0] grp, bank;
  integer n_mismatch = 0, n_checks = 0, cyc_n = 0, i;
  integer seed = 32'h3408b8f4;
  reg [7:0] q[$];
  reg [7:0] d;
  reg rd_seen = 0;
  initial forever #5 clk = ~clk;
  brf_core_model brf_core_model_inst(.clk(clk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  brf_register_file brf_register_file_inst(.clk(clk), .rst(rst),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_out_0(p0), .port_out_1(p1), .port_out_2(p2),
    .port_out_3(p3), .working_group(grp), .expanded_bank(bank));
  task check(input [7:0] seen, input [7:0] exp, input string what);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    brf_core_model_inst.cyc(1'b1, a, v);
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    q.push_back(e);
    brf_core_model_inst.cyc(1'b0, a, 8'h00);
  endtask
  task settle;
    brf_core_model_inst.idle;
    #1;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (rd_seen) check(rdata, q.pop_front(), "rdata");
    rd_seen <= rd & clk_en;
    if (cyc_n == 2000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    for (i = 6; i < 16; i = i + 1)
      rd_chk(8'hF0 | i[7:0], i == 8 ? 8'hCF : 8'h00);
    $display("test reset values done");
    for (i = 6; i < 16; i = i + 1) begin
      if (i != 13) begin
        d = $random(seed);
        wr_reg(8'hF0 | i[7:0], d);
        rd_chk(8'hF0 | i[7:0], d);
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      d = $random(seed);
      wr_reg(8'h04 + i[7:0] * 8'h1C, d);
      rd_chk(8'h04 + i[7:0] * 8'h1C, d);
    end
    for (i = 0; i < 4; i = i + 1)
      wr_reg(i[7:0], 8'hA0 | i[7:0]);
    settle;
    check(p0, 8'hA0, "port0");
    check(p1, 8'hA1, "port1");
    check(p2, 8'hA2, "port2");
    check(p3, 8'hA3, "port3");
    $display("test general and port registers done");
    wr_reg(8'hFD, 8'hDF);
    wr_reg(8'h05, 8'h5A);
    wr_reg(8'hE3, 8'h3C);
    wr_reg(8'hFD, 8'hDD);
    wr_reg(8'h05, 8'hA5);
    rd_chk(8'h05, 8'hA5);
    wr_reg(8'hFD, 8'hD3);
    wr_reg(8'h05, 8'h77);
    rd_chk(8'h05, 8'h00);
    wr_reg(8'hFD, 8'hDF);
    rd_chk(8'h05, 8'h5A);
    settle;
    check({grp, bank}, 8'hDF, "pointer outputs");
    wr_reg(8'hFD, 8'h00);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'hD3, 8'h3C);
    wr_reg(8'hF0, 8'hFF);
    rd_chk(8'hF0, 8'h00);
    settle;
    $display("test banks and pointer done");
    @(posedge clk);
    clk_en <= 0;
    wr_reg(8'h30, 8'h99);
    wr_reg(8'hFD, 8'h5A);
    brf_core_model_inst.idle;
    clk_en <= 1;
    rd_chk(8'h30, 8'h00);
    settle;
    check({grp, bank}, 8'h00, "frozen pointer");
    repeat (2) @(posedge clk);
    $display("test clock enable done");
    tally_and_finish;
  end
endmodule
